// ### logic/bgms_pkg.sv
// Package: constants for the battery gauge measurement sequencer
package bgms_pkg;
  // APB register byte offsets
  localparam logic [7:0] BGMS_MODE_OFS    = 8'h00;
  localparam logic [7:0] BGMS_CTRL_OFS    = 8'h04;
  localparam logic [7:0] BGMS_CHARGE_OFS  = 8'h08;
  localparam logic [7:0] BGMS_COUNTER_OFS = 8'h0C;
  localparam logic [7:0] BGMS_CURRENT_OFS = 8'h10;
  localparam logic [7:0] BGMS_VOLTAGE_OFS = 8'h14;
  localparam logic [7:0] BGMS_SOCBASE_OFS = 8'h18;
  localparam logic [7:0] BGMS_STATUS_OFS  = 8'h1C;
  // Mode register fields
  localparam int BGMS_LOWPWR_BIT = 0;
  localparam int BGMS_RUN_BIT    = 4;
  // Control register fields
  localparam int BGMS_CLEAR_BIT  = 1;
  // Widths
  localparam int BGMS_ADC_W   = 14;
  localparam int BGMS_ACC_W   = 28;
  localparam int BGMS_CNT_W   = 16;
  // Time base: tick cycles per slot
  localparam int BGMS_TICK_HZ      = 32768;
  localparam int BGMS_VOLT_TICKS   = 8192;            // 250 ms
  localparam int BGMS_CURR_MS      = 500;
  localparam int BGMS_CURR_TICKS   = BGMS_TICK_HZ * BGMS_CURR_MS / 1000;
  localparam int BGMS_PERIOD_MS    = 4000;
  localparam int BGMS_PERIOD_TICKS = BGMS_TICK_HZ * BGMS_PERIOD_MS / 1000;
  // Sequencer states
  typedef enum logic [1:0] {
    BGMS_IDLE,
    BGMS_VOLT,
    BGMS_CURR,
    BGMS_REST
  } bgms_state_t;
endpackage : bgms_pkg

// ### logic/bgms_sync.sv
// Two-flop synchroniser with rising edge detect on the synchronised level
`timescale 1ns/10ps
`default_nettype none
module bgms_sync (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  // Asynchronous level in
  input  wire logic async_i,
  // Synchronised level and rising pulse
  output logic      level_o,
  output logic      rise_o
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // First flop feeds only the second
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~prev_reg;
endmodule : bgms_sync
`default_nettype wire

// ### logic/bgms_top.sv
// Measurement sequencer and coulomb counter with APB registers
// How it works
// - One 14-bit converter; voltage and current slots never overlap.
// - Mode bit low_power_select picks power-saving or active schedule.
// - Power-saving: each current slot is followed by an idle slot of the same length.
// - Active: back-to-back current slots, one voltage slot per 4 s.
// - One voltage conversion every 4 s while running.
// - Undervoltage lockout stops all measurement.
// - Registers kept through lockout; reset restores defaults, gauge clear zeroes accumulator and counter.
// - Clearing run halts measurement and freezes results.
// - Setting run again resumes without clearing accumulated values.
// - Voltage slot is 8192 ticks of the 32768 Hz time base.
// - Voltage code spans 0-5 V at 0.305 mV per step.
// - Current slot lasts 500 ms and yields a 14-bit result.
// - Current results are signed two's complement.
// - Each completed current slot adds to accumulator and bumps counter.
// - Accumulator is 28 bits summing signed current results.
// - Charge is accumulator top 16 bits plus SOC base.
// - Host controls counter, writes SOC base, reads charge over registers.
// - After run is set, a voltage slot comes first.
// - Accumulator updates at the end of each 500 ms current slot with its result.
// - Clearing run mid current slot aborts and discards it.
`timescale 1ns/10ps
`default_nettype none
module bgms_top
  import bgms_pkg::*;
#(
  parameter int VOLT_TICKS   = BGMS_VOLT_TICKS,
  parameter int CURR_TICKS   = BGMS_CURR_TICKS,
  parameter int PERIOD_TICKS = BGMS_PERIOD_TICKS
) (
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  nrst_i,
  // APB slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // Time base and supply monitor (asynchronous)
  input  wire logic                  tick_clk_i,
  input  wire logic                  undervoltage_lockout_i,
  // Converter interface
  input  wire logic [BGMS_ADC_W-1:0] adc_result_i,
  output logic                       adc_volt_o,
  output logic                       adc_curr_o
);
  // Period counter width; the full 4 s count needs 17 bits, not 16
  localparam int PW = $clog2(PERIOD_TICKS);
  logic                  tick;
  logic                  undervoltage_lockout;
  bgms_state_t           state_reg;
  logic [15:0]           slot_reg;
  logic [PW-1:0]         period_reg;
  logic                  volt_pend_reg;
  logic                  low_power_select_reg;
  logic                  measure_run_reg;
  logic                  gauge_clear;
  logic [BGMS_ADC_W-1:0] voltage_reg;
  logic [BGMS_ADC_W-1:0] current_reg;
  logic [BGMS_ACC_W-1:0] acc_reg;
  logic [BGMS_CNT_W-1:0] count_reg;
  logic [15:0]           socbase_reg;
  logic [15:0]           charge_next;
  logic                  active;
  logic                  wr_en;
  logic                  rd_en;
  logic                  volt_due;
  logic                  slot_end;
  logic                  curr_done;

  // Synchronise time-base edges
  bgms_sync u_tick (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .async_i (tick_clk_i),
    .level_o (),
    .rise_o  (tick)
  );

  // Synchronise lockout level
  bgms_sync u_undervoltage_lockout (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .async_i (undervoltage_lockout_i),
    .level_o (undervoltage_lockout),
    .rise_o  ()
  );

  assign active    = measure_run_reg & ~undervoltage_lockout;
  assign wr_en     = psel_i & penable_i & pwrite_i;
  assign rd_en     = psel_i & ~penable_i & ~pwrite_i;
  assign gauge_clear = wr_en && (paddr_i == BGMS_CTRL_OFS) && pwdata_i[BGMS_CLEAR_BIT];
  assign slot_end  = tick && (state_reg != BGMS_IDLE) &&
                     (slot_reg == 16'(((state_reg == BGMS_VOLT) ? VOLT_TICKS : CURR_TICKS) - 1));
  // voltage due once per 4 s period
  // Slot ends seldom meet the wrap itself, so the request is held in a flag
  assign volt_due  = volt_pend_reg;
  assign curr_done = slot_end && (state_reg == BGMS_CURR) && active;
  // charge sum, wraps at 16 bits
  assign charge_next = acc_reg[BGMS_ACC_W-1 -: 16] + socbase_reg;

  // Mode and SOC base registers; only reset restores them
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      low_power_select_reg <= 1'b0;
      measure_run_reg      <= 1'b0;
      socbase_reg          <= 16'h0000;
    end else if (wr_en && paddr_i == BGMS_MODE_OFS) begin
      low_power_select_reg <= pwdata_i[BGMS_LOWPWR_BIT];
      measure_run_reg      <= pwdata_i[BGMS_RUN_BIT];
    end else if (wr_en && paddr_i == BGMS_SOCBASE_OFS) begin
      socbase_reg <= pwdata_i[15:0];
    end
  end

  // Sequencer: one slot at a time keeps the converter unshared
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_reg <= BGMS_IDLE;
      slot_reg  <= 16'h0000;
    end else if (!active) begin
      state_reg <= BGMS_IDLE;
      slot_reg  <= 16'h0000;
    end else begin
      case (state_reg)
        BGMS_IDLE: begin
          state_reg <= BGMS_VOLT;
          slot_reg  <= 16'h0000;
        end
        default: begin
          if (slot_end) begin
            slot_reg <= 16'h0000;
            if (state_reg == BGMS_CURR && low_power_select_reg) begin
              // idle slot after each current slot
              state_reg <= BGMS_REST;
            end else if (volt_due && state_reg != BGMS_VOLT) begin
              // voltage takes one slot per period
              state_reg <= BGMS_VOLT;
            end else begin
              state_reg <= BGMS_CURR;
            end
          end else if (tick) begin
            slot_reg <= slot_reg + 16'h0001;
          end
        end
      endcase
    end
  end

  // Period timer counting 4 s; preserved across stops
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      period_reg <= '0;
    end else if (active && tick) begin
      period_reg <= (period_reg == PW'(PERIOD_TICKS - 1)) ? '0 : period_reg + PW'(1);
    end
  end

  // voltage owed after each period wrap, taken at the next slot boundary, after the rest slot in low power
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      volt_pend_reg <= 1'b0;
    end else if (active && tick && period_reg == PW'(PERIOD_TICKS - 1)) begin
      // A wrap in the cycle a voltage slot ends wins over the clear
      volt_pend_reg <= 1'b1;
    end else if (slot_end && active && state_reg == BGMS_VOLT) begin
      // Voltage just measured, nothing owed until the next wrap
      volt_pend_reg <= 1'b0;
    end
  end

  // Results, accumulator and counter
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      voltage_reg <= '0;
      current_reg <= '0;
      acc_reg     <= '0;
      count_reg   <= '0;
    end else if (gauge_clear) begin
      acc_reg     <= '0;
      count_reg   <= '0;
    end else if (slot_end && active) begin
      // voltage code latched at slot end
      if (state_reg == BGMS_VOLT) begin
        voltage_reg <= adc_result_i;
      end
      if (curr_done) begin
        current_reg <= adc_result_i;
        acc_reg     <= acc_reg + {{(BGMS_ACC_W-BGMS_ADC_W){adc_result_i[BGMS_ADC_W-1]}},
                                   adc_result_i};
        count_reg   <= count_reg + 16'h0001;
      end
    end
  end

  // Converter strobes registered from state
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      adc_volt_o <= 1'b0;
      adc_curr_o <= 1'b0;
    end else begin
      adc_volt_o <= active && state_reg == BGMS_VOLT;
      adc_curr_o <= active && state_reg == BGMS_CURR;
    end
  end

  // APB read path, zero-wait; unmapped reads zero with error
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      if (psel_i & ~penable_i) begin
        prdata_o <= 32'h0000_0000;
        if (paddr_i == BGMS_MODE_OFS) begin
          prdata_o[BGMS_LOWPWR_BIT] <= low_power_select_reg;
          prdata_o[BGMS_RUN_BIT]    <= measure_run_reg;
        end else if (paddr_i == BGMS_CTRL_OFS) begin
          prdata_o <= 32'h0000_0000;
        end else if (paddr_i == BGMS_CHARGE_OFS) begin
          prdata_o[15:0] <= charge_next;
        end else if (paddr_i == BGMS_COUNTER_OFS) begin
          prdata_o[15:0] <= count_reg;
        end else if (paddr_i == BGMS_CURRENT_OFS) begin
          prdata_o <= {{(32-BGMS_ADC_W){current_reg[BGMS_ADC_W-1]}}, current_reg};
        end else if (paddr_i == BGMS_VOLTAGE_OFS) begin
          prdata_o[BGMS_ADC_W-1:0] <= voltage_reg;
        end else if (paddr_i == BGMS_SOCBASE_OFS) begin
          prdata_o[15:0] <= socbase_reg;
        end else if (paddr_i == BGMS_STATUS_OFS) begin
          prdata_o[1:0] <= state_reg;
          prdata_o[2]   <= undervoltage_lockout;
        end else begin
          pslverr_o <= rd_en | (psel_i & pwrite_i);
        end
      end
    end
  end

  // Assertions
  // a_slot_exclusive: converter never in both modes
  a_slot_exclusive: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !(adc_volt_o && adc_curr_o)) else $error("both conversions active");
  a_halt_idle: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !active |=> state_reg == BGMS_IDLE) else $error("sequencer not halted");
  a_start_volt: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    state_reg == BGMS_IDLE && active |=> state_reg == BGMS_VOLT) else $error("start not voltage");
  a_lp_rest: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    curr_done && low_power_select_reg |=> state_reg == BGMS_REST) else $error("no rest slot");
  a_count_inc: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    curr_done && !gauge_clear |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter not bumped");
  a_freeze_acc: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !active && !gauge_clear |=> $stable(acc_reg) && $stable(count_reg))
    else $error("results changed while stopped");
  a_undervoltage_lockout_stop: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    undervoltage_lockout |=> !adc_curr_o ##1 !adc_curr_o) else $error("converting in lockout");
  a_charge_sum: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    psel_i && !penable_i && paddr_i == BGMS_CHARGE_OFS |=> prdata_o[15:0] == $past(charge_next))
    else $error("charge sum wrong");
  // Schedule and register checks
  a_volt_taken: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    curr_done && volt_pend_reg && !low_power_select_reg |=> state_reg == BGMS_VOLT)
    else $error("voltage slot skipped");
  a_volt_once: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    slot_end && active && state_reg == BGMS_VOLT |=> state_reg != BGMS_VOLT)
    else $error("voltage slot repeated");
  a_volt_latch: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    slot_end && active && state_reg == BGMS_VOLT |=> voltage_reg == $past(adc_result_i))
    else $error("voltage result not taken");
  a_clear_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    gauge_clear |=> acc_reg == '0 && count_reg == '0)
    else $error("gauge clear ignored");
  a_apb_ready: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    psel_i && !penable_i |=> pready_o)
    else $error("no ready in access phase");
  c_volt_slot: cover property (@(posedge mclk_i) slot_end && state_reg == BGMS_VOLT);
  c_volt_repeat: cover property (@(posedge mclk_i) curr_done && volt_pend_reg);
  c_resume_run: cover property (@(posedge mclk_i) $rose(measure_run_reg));
  c_curr_done: cover property (@(posedge mclk_i) curr_done);
  c_rest_slot: cover property (@(posedge mclk_i) state_reg == BGMS_REST);
endmodule : bgms_top
`default_nettype wire

// ### testbench/bgms_conv_model.sv
// Converter and free-running time base model facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module bgms_conv_model (
  // Slot levels from the sequencer
  input  wire logic        volt_i,
  input  wire logic        curr_i,
  // Time base and converter result
  output logic             tick_o,
  output logic [13:0]      result_o
);
  logic [13:0] junk_reg = 14'h0155;
  // Time base runs free at 200 ns; offset keeps its edges off mclk edges
  initial begin
    tick_o = 1'b0;
    #3;
    forever #100 tick_o = ~tick_o;
  end
  // Outside a slot the result changes every tick, so a stale sample shows
  always @(posedge tick_o) junk_reg <= ~junk_reg;
  // one result per slot, signed current code
  assign result_o = volt_i ? 14'h1ABC : (curr_i ? 14'h2000 : junk_reg);
endmodule : bgms_conv_model
`default_nettype wire

// ### testbench/testbench.sv
// Testbench for the measurement sequencer: APB host, slot timing, results
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import bgms_pkg::*;
  localparam int          CT   = 16;
  localparam logic [31:0] RUN  = 32'h1 << BGMS_RUN_BIT;
  localparam logic [31:0] LOWP = 32'h1 << BGMS_LOWPWR_BIT;
  logic        mclk_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, lock_i = 1'b0, overlap = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rdata_q;
  logic        pready_o, pslverr_o, err_q, tick, adc_volt_o, adc_curr_o;
  logic [13:0] adc_res;
  int          miscompares = 0, total_checks = 0, waited, vw_cnt = 0, vw_last = 0;
  always #12.5 mclk_i = ~mclk_i;
  // Voltage slot width in mclk cycles, and any overlap of the two slots
  always @(posedge mclk_i) begin
    vw_cnt <= adc_volt_o ? vw_cnt + 1 : 0;
    if (!adc_volt_o && vw_cnt != 0) vw_last <= vw_cnt;
    if (adc_volt_o && adc_curr_o) overlap <= 1'b1;
  end
  // Counts shortened: 8 ticks of 8 mclk per voltage slot
  bgms_top #(.VOLT_TICKS(8), .CURR_TICKS(CT), .PERIOD_TICKS(128)) u_bgms_top (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .tick_clk_i(tick), .undervoltage_lockout_i(lock_i), .adc_result_i(adc_res),
    .adc_volt_o(adc_volt_o), .adc_curr_o(adc_curr_o));
  bgms_conv_model u_bgms_conv_model (
    .volt_i(adc_volt_o), .curr_i(adc_curr_o), .tick_o(tick), .result_o(adc_res));
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  task fail_out;
    miscompares++;
    $display("MISMATCH t=%0t wait ran out", $time);
    complete_run();
  endtask : fail_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rdata_q = prdata_o;
    err_q = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) fail_out();
  endtask : apb
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata_q, exp);
  endtask : rd_chk
  task wait_lvl(input logic curr, input logic lvl);
    waited = 0;
    while ((curr ? adc_curr_o : adc_volt_o) !== lvl && waited < 4000) begin
      @(posedge mclk_i);
      waited++;
    end
    if (waited >= 4000) fail_out();
  endtask : wait_lvl
  // Polls the conversion counter; a slot lasts far longer than one poll
  task wait_count(input logic [31:0] target);
    int n;
    for (n = 0; n < 900; n++) begin
      apb(1'b0, BGMS_COUNTER_OFS, 32'h0);
      if (rdata_q === target) break;
    end
    if (n >= 900) fail_out();
  endtask : wait_count
  // Charge for n results of -8192 on a base of 0x1234, wrapping
  function automatic logic [31:0] exp_charge(input logic [31:0] n);
    logic [27:0] acc;
    acc = 28'h0 - 28'h2000 * n[27:0];
    return {16'h0000, 16'h1234 + acc[27:12]};
  endfunction : exp_charge
  task t_reset;
    rd_chk(BGMS_MODE_OFS, 32'h0);
    rd_chk(BGMS_COUNTER_OFS, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    chk(rdata_q, 32'h0);
  endtask : t_reset
  task t_active;
    apb(1'b1, BGMS_CTRL_OFS, 32'h1 << BGMS_CLEAR_BIT);
    apb(1'b1, BGMS_SOCBASE_OFS, 32'h1234);
    apb(1'b1, BGMS_MODE_OFS, RUN);
    wait_lvl(1'b0, 1'b1);
    chk({31'h0, adc_curr_o}, 32'h0);
    wait_count(32'h3);
    rd_chk(BGMS_VOLTAGE_OFS, 32'h1ABC);
    rd_chk(BGMS_CURRENT_OFS, 32'hFFFF_E000);
    rd_chk(BGMS_CHARGE_OFS, exp_charge(32'h3));
    rd_chk(BGMS_MODE_OFS, RUN);
    // Next voltage slot follows the period wrap; it starts on a tick, so it
    // spans exactly 8 ticks of 8 mclk, unlike the first one
    wait_lvl(1'b0, 1'b1);
    wait_lvl(1'b0, 1'b0);
    // Width counter settles one edge after the strobe is seen low
    @(posedge mclk_i);
    chk(vw_last, 32'h40);
  endtask : t_active
  task t_stop;
    logic [31:0] c0, q0;
    wait_lvl(1'b1, 1'b1);
    apb(1'b1, BGMS_MODE_OFS, 32'h0);
    apb(1'b0, BGMS_COUNTER_OFS, 32'h0);
    c0 = rdata_q;
    apb(1'b0, BGMS_CHARGE_OFS, 32'h0);
    q0 = rdata_q;
    // Longer than a whole current slot, so a missed abort would count
    repeat (CT * 10) @(posedge mclk_i);
    chk({31'h0, adc_curr_o}, 32'h0);
    rd_chk(BGMS_COUNTER_OFS, c0);
    rd_chk(BGMS_CHARGE_OFS, q0);
    apb(1'b1, BGMS_MODE_OFS, RUN);
    wait_lvl(1'b0, 1'b1);
    chk({31'h0, adc_curr_o}, 32'h0);
    wait_count(c0 + 32'h1);
    rd_chk(BGMS_CHARGE_OFS, exp_charge(c0 + 32'h1));
  endtask : t_stop
  task t_lowpwr;
    apb(1'b1, BGMS_MODE_OFS, RUN | LOWP);
    wait_lvl(1'b1, 1'b1);
    wait_lvl(1'b1, 1'b0);
    wait_lvl(1'b1, 1'b1);
    chk({31'h0, waited >= CT * 8 - 4}, 32'h1);
  endtask : t_lowpwr
  task t_lockout;
    logic [31:0] c0;
    lock_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    apb(1'b0, BGMS_COUNTER_OFS, 32'h0);
    c0 = rdata_q;
    repeat (CT * 10) @(posedge mclk_i);
    chk({31'h0, adc_curr_o | adc_volt_o}, 32'h0);
    rd_chk(BGMS_COUNTER_OFS, c0);
    rd_chk(BGMS_SOCBASE_OFS, 32'h1234);
    rd_chk(BGMS_STATUS_OFS, 32'h4);
    lock_i <= 1'b0;
    apb(1'b1, BGMS_MODE_OFS, 32'h0);
    apb(1'b1, BGMS_CTRL_OFS, 32'h1 << BGMS_CLEAR_BIT);
    rd_chk(BGMS_COUNTER_OFS, 32'h0);
    rd_chk(BGMS_CHARGE_OFS, 32'h1234);
  endtask : t_lockout
  initial begin
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_active();
    t_stop();
    t_lowpwr();
    t_lockout();
    chk({31'h0, overlap}, 32'h0);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
